// >>> logic/dse_rmw_engine.sv
// decorated store read-modify-write stage between crossbar port and peripheral bus
`timescale 1ns/1ps

module dse_rmw_engine
  import dse_pkg::*;
(
  input  wire logic        i_clock,    // platform clock, 100 MHz
  input  wire logic        i_rstn,     // async reset, active low
  // crossbar side, this block is the slave
  input  wire logic        i_hsel,     // slave select
  input  wire logic [31:0] i_haddr,    // address, possibly decorated
  input  wire logic [1:0]  i_htrans,   // transfer type
  input  wire logic        i_hwrite,   // write when high
  input  wire logic [2:0]  i_hsize,    // transfer size
  input  wire logic [3:0]  i_hprot,    // protection attributes
  input  wire logic [31:0] i_hwdata,   // write data
  output logic             o_hready,   // transfer done to master
  output logic             o_hresp,    // response to master
  output logic [31:0]      o_hrdata,   // read data to master
  // peripheral side, this block is the master
  output logic [31:0]      o_p_haddr,  // real address
  output logic [1:0]       o_p_htrans, // transfer type
  output logic             o_p_hwrite, // write when high
  output logic [2:0]       o_p_hsize,  // transfer size
  output logic [3:0]       o_p_hprot,  // protection attributes
  output logic [31:0]      o_p_hwdata, // write data
  input  wire logic        i_p_hready, // peripheral done
  input  wire logic        i_p_hresp,  // peripheral response
  input  wire logic [31:0] i_p_hrdata  // peripheral read data
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // decode the decoration carried in the upper address bits
  function automatic dse_dec_s dse_decode(input logic [31:0] a, input logic wr);
    dse_dec_s d;
    d.hit       = wr && (a[31:DEC_REGION_LSB] == DEC_REGION) && (a[28:DEC_OP_LSB] != 3'h0);
    d.lsb       = a[27:DEC_LSB_POS];
    d.wid       = a[22:DEC_WIDTH_POS];
    d.op        = OP_AND;
    d.real_addr = a & LOGIC_ADDR_MASK;
    if (a[DEC_FI_BIT]) begin
      d.op        = OP_FIELD;
      d.real_addr = a & FIELD_ADDR_MASK;
    end else if (a[28:DEC_OP_LSB] == DEC_CODE_OR) begin
      d.op = OP_OR;
    end else if (a[28:DEC_OP_LSB] == DEC_CODE_XOR) begin
      d.op = OP_XOR;
    end
    return d;
  endfunction : dse_decode

  // insert mask inside the container, moved to its byte lane
  function automatic logic [31:0] dse_field_mask(input logic [4:0] lsb, input logic [3:0] wid,
                                                 input logic [2:0] size, input logic [1:0] lane);
    logic [63:0] raw;
    logic [31:0] cont;
    raw  = ((64'h1 << ({2'h0, wid} + 6'h01)) - 64'h1) << lsb;
    cont = 32'hffff_ffff;
    if (size == HSIZE_BYTE) begin
      cont = 32'h0000_00ff;
    end else if (size == HSIZE_HALF) begin
      cont = 32'h0000_ffff;
    end
    // clipping to the container drops the overhanging field bits
    return (raw[31:0] & cont) << {lane, 3'h0};
  endfunction : dse_field_mask

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rstn_sync;

  // async assert, release through two flops
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta  <= 1'b0;
      rstn_sync <= 1'b0;
    end else begin
      rst_meta  <= 1'b1;
      rstn_sync <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // address phase decode
  // ---------------------------------------------------------------
  dse_state_e  state;
  dse_state_e  next_state;
  dse_aphase_s cap;
  dse_aphase_s next_cap;
  dse_op_e     cap_op;
  dse_op_e     next_cap_op;
  logic [4:0]  cap_lsb;
  logic [4:0]  next_cap_lsb;
  logic [3:0]  cap_wid;
  logic [3:0]  next_cap_wid;
  logic [31:0] mod_data;
  logic [31:0] next_mod_data;
  dse_dec_s    dec;
  logic        take;
  logic        take_dec;
  logic [31:0] field_mask;

  assign dec      = dse_decode(i_haddr, i_hwrite);
  // the read state blocks the master address phase from being taken
  assign take     = (state != ST_READ) && i_p_hready && i_hsel && i_htrans[1];
  assign take_dec = take && dec.hit;

  // ---------------------------------------------------------------
  // sequence control
  // ---------------------------------------------------------------

  // next state, captured attributes and modified data
  always_comb begin
    next_state    = state;
    next_cap      = cap;
    next_cap_op   = cap_op;
    next_cap_lsb  = cap_lsb;
    next_cap_wid  = cap_wid;
    next_mod_data = mod_data;
    case (state)
      ST_PASS, ST_WRITE: begin
        if (i_p_hready) begin
          next_state = ST_PASS;
          if (take_dec) begin
            next_state   = ST_READ;
            next_cap     = '{addr: dec.real_addr, trans: HTRANS_NONSEQ, write: 1'b1,
                             size: i_hsize, prot: i_hprot};
            next_cap_op  = dec.op;
            next_cap_lsb = dec.lsb;
            next_cap_wid = dec.wid;
          end
        end
      end
      ST_READ: begin
        // wait states simply stretch this phase
        if (i_p_hready) begin
          next_state = ST_WRITE;
          // write data is replicated over all lanes, so full width is safe
          case (cap_op)
            OP_AND:  next_mod_data = i_p_hrdata & i_hwdata;
            OP_OR:   next_mod_data = i_p_hrdata | i_hwdata;
            OP_XOR:  next_mod_data = i_p_hrdata ^ i_hwdata;
            default: next_mod_data = (i_hwdata & field_mask) | (i_p_hrdata & ~field_mask);
          endcase
        end
      end
      default: begin
        next_state = ST_PASS;
      end
    endcase
  end

  // insert mask from the captured decoration, ready before the read data arrives
  assign field_mask = dse_field_mask(cap_lsb, cap_wid, cap.size, cap.addr[1:0]);

  // registers of the sequence
  always_ff @(posedge i_clock or negedge rstn_sync) begin
    if (!rstn_sync) begin
      state    <= ST_PASS;
      cap      <= '0;
      cap_op   <= OP_AND;
      cap_lsb  <= RST_LSB;
      cap_wid  <= RST_WID;
      mod_data <= RST_DATA;
    end else begin
      state    <= next_state;
      cap      <= next_cap;
      cap_op   <= next_cap_op;
      cap_lsb  <= next_cap_lsb;
      cap_wid  <= next_cap_wid;
      mod_data <= next_mod_data;
    end
  end

  // ---------------------------------------------------------------
  // bus steering
  // ---------------------------------------------------------------

  // address phase: pass through, read with stripped address, or recirculated write
  always_comb begin
    o_p_haddr  = i_haddr;
    o_p_htrans = i_hsel ? i_htrans : HTRANS_IDLE;
    o_p_hwrite = i_hwrite;
    o_p_hsize  = i_hsize;
    o_p_hprot  = i_hprot;
    if (state == ST_READ) begin
      o_p_haddr  = cap.addr;
      o_p_htrans = cap.trans;
      o_p_hwrite = cap.write;
      o_p_hsize  = cap.size;
      o_p_hprot  = cap.prot;
    end else if (i_hsel && dec.hit) begin
      o_p_haddr  = dec.real_addr;
      o_p_hwrite = 1'b0;
    end
  end

  // data phase: modified value on the write, stall during the read
  // outputs stay combinational so undecorated traffic sees no extra cycle
  assign o_p_hwdata = (state == ST_WRITE) ? mod_data : i_hwdata;
  assign o_hready   = (state == ST_READ) ? 1'b0 : i_p_hready;
  assign o_hresp    = (state == ST_READ) ? HRESP_OKAY : i_p_hresp;
  assign o_hrdata   = i_p_hrdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_read_first;
    @(posedge i_clock) disable iff (!rstn_sync)
      take_dec |-> !o_p_hwrite && (o_p_haddr == dec.real_addr) ##1 state == ST_READ;
  endproperty
  a_read_first: assert property (p_read_first) else $error("decorated store not issued as read");

  property p_write_second;
    @(posedge i_clock) disable iff (!rstn_sync)
      take_dec |=> o_p_hwrite && (o_p_htrans == HTRANS_NONSEQ) && (o_p_haddr == $past(dec.real_addr));
  endproperty
  a_write_second: assert property (p_write_second) else $error("recirculated write address wrong");

  property p_write_data;
    @(posedge i_clock) disable iff (!rstn_sync)
      (state == ST_READ) && i_p_hready |=> (state == ST_WRITE) && (o_p_hwdata == mod_data);
  endproperty
  a_write_data: assert property (p_write_data) else $error("modified data not on write bus");

  property p_or_value;
    @(posedge i_clock) disable iff (!rstn_sync)
      (state == ST_READ) && i_p_hready && (cap_op == OP_OR) |=> mod_data == $past(i_p_hrdata | i_hwdata);
  endproperty
  a_or_value: assert property (p_or_value) else $error("or result wrong");

  property p_xor_value;
    @(posedge i_clock) disable iff (!rstn_sync)
      (state == ST_READ) && i_p_hready && (cap_op == OP_XOR) |=> mod_data == $past(i_p_hrdata ^ i_hwdata);
  endproperty
  a_xor_value: assert property (p_xor_value) else $error("xor result wrong");

  property p_and_value;
    @(posedge i_clock) disable iff (!rstn_sync)
      (state == ST_READ) && i_p_hready && (cap_op == OP_AND) |=> mod_data == $past(i_p_hrdata & i_hwdata);
  endproperty
  a_and_value: assert property (p_and_value) else $error("and result wrong");

  property p_logic_mask;
    @(posedge i_clock) disable iff (!rstn_sync)
      take_dec && !i_haddr[DEC_FI_BIT] |-> o_p_haddr == (i_haddr & LOGIC_ADDR_MASK);
  endproperty
  a_logic_mask: assert property (p_logic_mask) else $error("logic op address not stripped");

  property p_field_mask;
    @(posedge i_clock) disable iff (!rstn_sync)
      take_dec && i_haddr[DEC_FI_BIT] |-> o_p_haddr == (i_haddr & FIELD_ADDR_MASK);
  endproperty
  a_field_mask: assert property (p_field_mask) else $error("field insert address not stripped");

  property p_single_bit;
    @(posedge i_clock) disable iff (!rstn_sync)
      (state == ST_READ) && (cap_op == OP_FIELD) && (cap_wid == 4'h0) && (cap.size == 3'h2)
      |-> field_mask == (32'h1 << cap_lsb);
  endproperty
  a_single_bit: assert property (p_single_bit) else $error("width zero not a single bit");

  property p_stall;
    @(posedge i_clock) disable iff (!rstn_sync)
      take_dec ##1 (state == ST_READ) |-> !o_hready;
  endproperty
  a_stall: assert property (p_stall) else $error("master not stalled during modify");

  property p_hold_wait;
    @(posedge i_clock) disable iff (!rstn_sync)
      (state == ST_READ) && !i_p_hready |=> (state == ST_READ) && $stable(o_p_haddr) && !o_hready;
  endproperty
  a_hold_wait: assert property (p_hold_wait) else $error("wait state not held");

  property p_passthru;
    @(posedge i_clock) disable iff (!rstn_sync)
      (state != ST_READ) && !(i_hsel && dec.hit) |-> (o_p_haddr == i_haddr) && (o_hready == i_p_hready);
  endproperty
  a_passthru: assert property (p_passthru) else $error("plain access altered");

endmodule : dse_rmw_engine

// >>> shared/dse_pkg.sv
// shared constants, codes and carriers of the decorated store engine
package dse_pkg;

  // ---------------------------------------------------------------
  // bus codes
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE    = 3'h0;
  localparam logic [2:0] HSIZE_HALF    = 3'h1;
  localparam logic       HRESP_OKAY    = 1'h0;

  // ---------------------------------------------------------------
  // decoration layout
  // ---------------------------------------------------------------
  localparam logic [2:0]  DEC_REGION      = 3'h2;        // addr[31:29], periph alias
  localparam int          DEC_REGION_LSB  = 29;
  localparam int          DEC_OP_LSB      = 26;          // addr[28:26]
  localparam int          DEC_FI_BIT      = 28;          // field insert select
  localparam int          DEC_LSB_POS     = 23;          // addr[27:23]
  localparam int          DEC_WIDTH_POS   = 19;          // addr[22:19]
  localparam logic [2:0]  DEC_CODE_AND    = 3'h1;
  localparam logic [2:0]  DEC_CODE_OR     = 3'h2;
  localparam logic [2:0]  DEC_CODE_XOR    = 3'h3;
  localparam logic [31:0] LOGIC_ADDR_MASK = 32'he00fffff;
  localparam logic [31:0] FIELD_ADDR_MASK = 32'he007ffff;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_DATA = 32'h0000_0000;
  localparam logic [4:0]  RST_LSB  = 5'h00;
  localparam logic [3:0]  RST_WID  = 4'h0;

  typedef enum logic [1:0] {OP_AND, OP_OR, OP_XOR, OP_FIELD} dse_op_e;
  typedef enum logic [1:0] {ST_PASS, ST_READ, ST_WRITE} dse_state_e;

  // one address phase on either bus
  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  trans;
    logic        write;
    logic [2:0]  size;
    logic [3:0]  prot;
  } dse_aphase_s;

  // decoded decoration of an incoming address phase
  typedef struct packed {
    logic        hit;
    dse_op_e     op;
    logic [4:0]  lsb;
    logic [3:0]  wid;
    logic [31:0] real_addr;
  } dse_dec_s;

endpackage : dse_pkg

// >>> verif/dse_periph_model.sv
// peripheral bus slave model: small memory, wait states per data phase
`timescale 1ns/1ps
module dse_periph_model
  import dse_pkg::*;
(
  input  wire logic        i_clock,  // clock
  input  wire logic [31:0] i_haddr,  // address
  input  wire logic [1:0]  i_htrans, // transfer type
  input  wire logic        i_hwrite, // write when high
  input  wire logic [2:0]  i_hsize,  // size
  input  wire logic [31:0] i_hwdata, // write data
  input  wire logic [3:0]  i_waits,  // wait states per data phase
  output logic             o_hready, // data phase done
  output logic             o_hresp,  // response
  output logic [31:0]      o_hrdata  // read data
);
  // ------------------------------
  // data phase state
  // ------------------------------
  logic [31:0] mem [4];
  logic [31:0] junk  = 32'h1234abcd;
  logic [3:0]  cnt   = 4'h0;
  logic        act   = 1'b0;
  logic [3:0]  addr;
  logic [2:0]  size;
  logic        wr;
  logic [3:0]  lanes;
  // junk outside a valid read, so a stale value never looks right
  assign o_hready = !act || cnt == 4'h0;
  assign o_hresp  = HRESP_OKAY;
  assign o_hrdata = (act && !wr && o_hready) ? mem[addr[3:2]] : junk;
  assign lanes    = (size == HSIZE_BYTE) ? 4'h1 << addr[1:0] : (size == HSIZE_HALF) ? 4'h3 << addr[1:0] : 4'hf;
  // a write lands only at the last cycle of its data phase
  always @(posedge i_clock) begin
    junk <= junk * 32'h0019660d + 32'h3c6ef35f;
    if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    if (act && o_hready) begin
      act <= 1'b0;
      for (int i = 0; i < 4; i++)
        if (wr && lanes[i])
          mem[addr[3:2]][8*i +: 8] <= i_hwdata[8*i +: 8];
    end
    if (o_hready && i_htrans[1]) begin
      act  <= 1'b1;
      addr <= i_haddr[3:0];
      wr   <= i_hwrite;
      size <= i_hsize;
      cnt  <= i_waits;
    end
  end
endmodule : dse_periph_model

// >>> verif/dse_rmw_engine_tb.sv
// self-checking bench of the decorated store engine
`timescale 1ns/1ps
module dse_rmw_engine_tb;
  import dse_pkg::*;
  // ------------------------------
  // signals and bench state
  // ------------------------------
  logic        i_clock, i_rstn, i_hsel, i_hwrite, i_p_hready, i_p_hresp, o_hready, o_hresp, o_p_hwrite;
  logic        ap_wr, rp_wr, rsp;
  logic [1:0]  i_htrans, o_p_htrans;
  logic [2:0]  i_hsize, o_p_hsize, rp_sz, sz;
  logic [3:0]  i_hprot, o_p_hprot, rp_prot, pr, waits;
  logic [4:0]  b;
  logic [31:0] i_haddr, i_hwdata, i_p_hrdata, o_hrdata, o_p_haddr, o_p_hwdata, ap_addr, rp_addr, pw, r;
  logic [31:0] ref_mem [4];
  logic [31:0] lfsr        = 32'h000017ef; // fixed seed
  int          mismatches  = 0;
  int          comparisons = 0;

  dse_rmw_engine DUT (.i_clock, .i_rstn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hprot,
    .i_hwdata, .o_hready, .o_hresp, .o_hrdata, .o_p_haddr, .o_p_htrans, .o_p_hwrite, .o_p_hsize,
    .o_p_hprot, .o_p_hwdata, .i_p_hready, .i_p_hresp, .i_p_hrdata);
  dse_periph_model periph (.i_clock, .i_haddr(o_p_haddr), .i_htrans(o_p_htrans), .i_hwrite(o_p_hwrite),
    .i_hsize(o_p_hsize), .i_hwdata(o_p_hwdata), .i_waits(waits), .o_hready(i_p_hready),
    .o_hresp(i_p_hresp), .o_hrdata(i_p_hrdata));

  // 100 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // expected word after the modify step; only the addressed lanes change
  function automatic logic [31:0] expect_word(logic [31:0] old, logic [31:0] wd, logic [2:0] op,
      logic fi, logic [4:0] bp, logic [3:0] w, logic [31:0] lm, int sh);
    logic [63:0] fm;
    logic [31:0] nw;
    fm = ((64'h1 << (w + 1)) - 64'h1) << (bp + sh);
    if (fi)
      nw = (old & ~fm[31:0]) | (wd & fm[31:0]);
    else if (op == DEC_CODE_AND)
      nw = old & wd;
    else if (op == DEC_CODE_OR)
      nw = old | wd;
    else
      nw = old ^ wd;
    return (nw & lm) | (old & ~lm);
  endfunction : expect_word

  // bounded wait for ready, counting data cycles at settled points
  task automatic wait_rdy(output int n);
    n = 1;
    while (o_hready !== 1'b1) begin
      @(negedge i_clock);
      n++;
      if (n > 40) begin
        mismatches++;
        report_and_stop();
      end
    end
  endtask : wait_rdy

  // one whole master transfer; peripheral side snapshots feed the checks
  task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] s, input logic [31:0] wd,
                      output logic [31:0] rd, output int n);
    pr = 4'(rnd());
    i_hsel   <= 1'b1;
    i_haddr  <= a;
    i_htrans <= HTRANS_NONSEQ;
    i_hwrite <= w;
    i_hsize  <= s;
    i_hprot  <= pr;
    i_hwdata <= ~i_hwdata;
    @(negedge i_clock);
    wait_rdy(n);
    ap_addr = o_p_haddr;
    ap_wr   = o_p_hwrite;
    @(posedge i_clock);
    i_htrans <= HTRANS_IDLE;
    i_hwdata <= wd;
    @(negedge i_clock);
    {rp_addr, rp_wr, rp_sz, rp_prot} = {o_p_haddr, o_p_hwrite, o_p_hsize, o_p_hprot};
    wait_rdy(n);
    rd  = o_hrdata;
    rsp = o_hresp;
    pw  = o_p_hwdata;
    @(posedge i_clock);
  endtask : xfer

  task automatic plain(input logic [1:0] ix, input logic w, input logic [31:0] d, input logic [27:0] hi);
    logic [31:0] rd;
    int          n;
    xfer({hi, ix, 2'h0}, w, 3'h2, d, rd, n);
    check(ap_addr, {hi, ix, 2'h0}, "plain address");
    check({31'h0, ap_wr}, {31'h0, w}, "plain direction");
    check({31'h0, rsp}, {31'h0, HRESP_OKAY}, "plain response");
    check(32'(n), 32'(1 + waits), "plain cycles");
    if (!w)
      check(rd, ref_mem[ix], "read back");
  endtask : plain

  // decorated store, checked at both buses, then read back
  task automatic dec(input logic fi, input logic [2:0] op, input logic [4:0] bp, input logic [3:0] w,
                     input logic [2:0] s, input logic [31:0] v);
    logic [31:0] a, wd, ex, rd, lm, am;
    logic [1:0]  ix, ln;
    int          n, sh;
    a  = rnd();
    ix = a[3:2];
    ln = a[1:0] & ((s == HSIZE_BYTE) ? 2'h3 : (s == HSIZE_HALF) ? 2'h2 : 2'h0);
    sh = 8 * ln;
    lm = ((s == HSIZE_BYTE) ? 32'h000000ff : (s == HSIZE_HALF) ? 32'h0000ffff : 32'hffffffff) << sh;
    am = fi ? FIELD_ADDR_MASK : LOGIC_ADDR_MASK;
    a  = fi ? {3'h2, 1'b1, bp, w, 15'h0, ix, ln} : {3'h2, op, a[25:20], 16'h0, ix, ln};
    wd = (s == HSIZE_BYTE) ? {4{v[7:0]}} : (s == HSIZE_HALF) ? {2{v[15:0]}} : v;
    ex = expect_word(ref_mem[ix], wd, op, fi, bp, w, lm, sh);
    xfer(a, 1'b1, s, wd, rd, n);
    check(ap_addr, a & am, "read address");
    check({31'h0, ap_wr}, 32'h0, "read phase");
    check(rp_addr, a & am, "write address");
    check({24'h0, rp_wr, rp_sz, rp_prot}, {24'h0, 1'b1, s, pr}, "write attributes");
    check(32'(n), 32'(2 + 2 * waits), "stall cycles");
    check({31'h0, rsp}, {31'h0, HRESP_OKAY}, "store response");
    check(pw & lm, ex & lm, "write data");
    ref_mem[ix] = ex;
    plain(ix, 1'b0, 32'h0, 28'h4000000);
  endtask : dec

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    {i_rstn, i_hsel, i_hwrite, i_hsize, i_hprot, i_haddr, i_hwdata, waits} = '0;
    i_htrans = HTRANS_IDLE;
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clock);
    for (int i = 0; i < 4; i++) begin
      ref_mem[i] = rnd();
      plain(2'(i), 1'b1, ref_mem[i], 28'h4000000);
    end
    // stores outside the peripheral region and decorated loads must pass untouched
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      ref_mem[k] = r;
      plain(2'(k), 1'b1, r, {3'h3, 3'(k + 1), r[21:0]});
      plain(2'(k), 1'b0, 32'h0, {3'h2, 3'(k + 1), r[21:0]});
    end
    // every logical op at every size, AND with 0, OR with 1 and XOR with 2 wait states
    for (int k = 0; k < 54; k++) begin
      waits <= 4'(k % 3);
      dec(1'b0, 3'(1 + k % 3), 5'h0, 4'h0, 3'((k / 3) % 3), rnd());
    end
    // width 3 at every lsb of a byte: the upper ones spill past the container
    for (int k = 0; k < 8; k++)
      dec(1'b1, 3'h0, 5'(k), 4'h2, HSIZE_BYTE, rnd());
    // single bit set and clear in a word
    for (int k = 0; k < 6; k++)
      dec(1'b1, 3'h0, 5'(k * 5), 4'h0, 3'h2, {32{k[0]}});
    // random field inserts, lsb kept inside the container
    for (int k = 0; k < 60; k++) begin
      r = rnd();
      sz = 3'(k % 3);
      b = r[4:0] & ((sz == HSIZE_BYTE) ? 5'h07 : (sz == HSIZE_HALF) ? 5'h0f : 5'h1f);
      waits <= 4'(r[31:30]);
      dec(1'b1, 3'h0, b, r[8:5], sz, rnd());
    end
    report_and_stop();
  end
endmodule : dse_rmw_engine_tb
